// ===== src/psch_pkg.sv
package psch_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int          FRAME_LEN  = 9;
  localparam int          HDR_LEN    = 8;
  localparam int          POS_ADDR   = 0;
  localparam int          POS_INSTR  = 1;
  localparam int          POS_TYPE   = 2;
  localparam int          POS_BANK   = 3;
  localparam int          POS_VAL3   = 4;
  localparam int          POS_VAL2   = 5;
  localparam int          POS_VAL1   = 6;
  localparam int          POS_VAL0   = 7;
  localparam logic [3:0]  CNT_LAST   = 4'h8;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [7:0]  DEF_ADDR   = 8'h01;

  // ---------------------------------------------------------------
  // Instruction codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  AXIS_PARAM_WRITE_CMD    = 8'h05;
  localparam logic [7:0]  AXIS_PARAM_READ_CMD     = 8'h06;
  localparam logic [7:0]  AXIS_PARAM_STORE_CMD    = 8'h07;
  localparam logic [7:0]  AXIS_PARAM_RESTORE_CMD  = 8'h08;
  localparam logic [7:0]  GLOBAL_PARAM_WRITE_CMD  = 8'h09;
  localparam logic [7:0]  GLOBAL_PARAM_READ_CMD   = 8'h0a;
  localparam logic [7:0]  GLOBAL_PARAM_STORE_CMD  = 8'h0b;
  localparam logic [7:0]  GLOBAL_PARAM_RESTORE_CMD = 8'h0c;

  // ---------------------------------------------------------------
  // Banks
  // ---------------------------------------------------------------
  localparam logic [7:0]  BANK_AXIS      = 8'h00;
  localparam logic [7:0]  BANK_SETTINGS  = 8'h00;
  localparam logic [7:0]  BANK_USER      = 8'h02;
  localparam logic [7:0]  BANK_IRQ       = 8'h03;
  localparam int          GBANKS         = 3;
  localparam logic [1:0]  GB_SETTINGS    = 2'h0;
  localparam logic [1:0]  GB_USER        = 2'h1;
  localparam logic [1:0]  GB_IRQ         = 2'h2;

  // ---------------------------------------------------------------
  // Reply status codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  STAT_OK        = 8'h64;
  localparam logic [7:0]  STAT_BAD_CSUM  = 8'h01;
  localparam logic [7:0]  STAT_BAD_CMD   = 8'h02;
  localparam logic [7:0]  STAT_BAD_TYPE  = 8'h03;
  localparam logic [7:0]  STAT_BAD_BANK  = 8'h04;

  localparam logic [31:0] VAL_ZERO       = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_INIT,
    ST_RECV,
    ST_EXEC
  } psch_state_t;

endpackage

// ===== src/psch_param_cmd.sv
// Operation
// RULE_01: Code 7 copies axis parameter to NV
// RULE_02: Code 8 reloads axis parameter from NV
// RULE_03: Power-up loads all axis parameters first
// RULE_04: Code 9 writes global parameter, banks 0/2/3
// RULE_05: Banks: 0 settings, 2 user, 3 irq
// RULE_06: Bank 0 writes also commit to NV
// RULE_07: Code 10 reads global into accumulator
// RULE_08: Global read reply carries value, status OK
// RULE_09: Code 11 copies global parameter to NV
// RULE_10: User variables reload at power-up or request
// RULE_11: Successful commands reply status 100
// RULE_12: Global read accepts every bank entry
// RULE_13: Code 5 writes working store only
// RULE_14: Direct mode read leaves accumulator alone
// RULE_15: Nine-byte frame, modulo-256 sum checksum
// RULE_16: Host waits for reply, zeros ignored fields
`timescale 1ns/1ns
`default_nettype none

module psch_param_cmd #(
  parameter int          PARAM_N     = 256,
  parameter logic [7:0]  MODULE_ADDR = psch_pkg::DEF_ADDR
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        rx_valid_i,
  input  wire logic [7:0]  rx_data_i,
  output logic             rx_ready_o,
  input  wire logic        standalone_i,
  input  wire logic        uvar_autorestore_i,
  output logic             init_done_o,
  output logic             reply_valid_o,
  output logic [7:0]       reply_instr_o,
  output logic [7:0]       reply_status_o,
  output logic [31:0]      reply_value_o,
  output logic [31:0]      accumulator_o,
  output logic             nv_commit_o
);

  localparam int IDX_W = (PARAM_N > 1) ? $clog2(PARAM_N) : 1;
  localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(PARAM_N - 1);
  localparam logic [IDX_W-1:0] IDX_ZERO = '0;

  // ---------------------------------------------------------------
  // Storage: working copies and non-volatile copies
  // ---------------------------------------------------------------
  logic [31:0] axis_work [PARAM_N];
  // Stand-in for a pre-erased NV part, keeps reads defined
  logic [31:0] axis_nv   [PARAM_N] = '{default: psch_pkg::VAL_ZERO};
  logic [31:0] glob_work [psch_pkg::GBANKS][PARAM_N];
  logic [31:0] glob_nv   [psch_pkg::GBANKS][PARAM_N] = '{default: psch_pkg::VAL_ZERO};

  // ---------------------------------------------------------------
  // Control state
  // ---------------------------------------------------------------
  psch_pkg::psch_state_t state_ff;
  logic [IDX_W-1:0] init_idx_ff;
  logic             autorest_ff;
  logic [3:0]       cnt_ff;
  logic [7:0]       csum_ff;
  logic [7:0]       frame_ff [psch_pkg::HDR_LEN];
  logic             csum_ok_ff;
  logic             addr_ok_ff;

  logic             rx_take;
  logic             uvar_rest_en;
  logic [7:0]       instr;
  logic [7:0]       bank;
  logic [7:0]       ptype;
  logic [IDX_W-1:0] idx;
  logic [31:0]      value;
  logic             type_ok;
  logic             gbank_ok;
  logic [1:0]       gsel;

  // Exec decode results
  logic             ok;
  logic [7:0]       status;
  logic [31:0]      rvalue;
  logic             ax_wr_work;
  logic             ax_wr_nv;
  logic             ax_restore;
  logic             gl_wr_work;
  logic             gl_wr_nv;
  logic             gl_restore;
  logic             acc_load;

  assign rx_take = rx_valid_i && (state_ff == psch_pkg::ST_RECV);
  assign rx_ready_o = (state_ff == psch_pkg::ST_RECV);
  assign init_done_o = (state_ff != psch_pkg::ST_INIT);

  assign instr = frame_ff[psch_pkg::POS_INSTR];
  assign bank  = frame_ff[psch_pkg::POS_BANK];
  assign ptype = frame_ff[psch_pkg::POS_TYPE];
  assign idx   = ptype[IDX_W-1:0];
  assign value = {frame_ff[psch_pkg::POS_VAL3], frame_ff[psch_pkg::POS_VAL2],
                  frame_ff[psch_pkg::POS_VAL1], frame_ff[psch_pkg::POS_VAL0]};
  assign type_ok = (int'(ptype) < PARAM_N);

  // Strap taken live on the first restore step, held afterwards
  assign uvar_rest_en = (init_idx_ff == IDX_ZERO) ? uvar_autorestore_i : autorest_ff; // RULE_10

  // ---------------------------------------------------------------
  // Bank mapping
  // ---------------------------------------------------------------
  always_comb begin
    gbank_ok = 1'b1;
    gsel     = psch_pkg::GB_SETTINGS;
    unique case (bank)
      psch_pkg::BANK_SETTINGS: gsel = psch_pkg::GB_SETTINGS; // RULE_05
      psch_pkg::BANK_USER:     gsel = psch_pkg::GB_USER;
      psch_pkg::BANK_IRQ:      gsel = psch_pkg::GB_IRQ;
      default:                 gbank_ok = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  always_comb begin
    ok         = 1'b0;
    status     = psch_pkg::STAT_BAD_CMD;
    rvalue     = psch_pkg::VAL_ZERO;
    ax_wr_work = 1'b0;
    ax_wr_nv   = 1'b0;
    ax_restore = 1'b0;
    gl_wr_work = 1'b0;
    gl_wr_nv   = 1'b0;
    gl_restore = 1'b0;
    acc_load   = 1'b0;
    if (!csum_ok_ff) begin
      status = psch_pkg::STAT_BAD_CSUM; // RULE_15
    end else begin
      unique case (instr)
        psch_pkg::AXIS_PARAM_WRITE_CMD,
        psch_pkg::AXIS_PARAM_READ_CMD,
        psch_pkg::AXIS_PARAM_STORE_CMD,
        psch_pkg::AXIS_PARAM_RESTORE_CMD: begin
          if (!type_ok) begin
            status = psch_pkg::STAT_BAD_TYPE;
          end else if (bank != psch_pkg::BANK_AXIS) begin
            status = psch_pkg::STAT_BAD_BANK;
          end else begin
            ok         = 1'b1;
            ax_wr_work = (instr == psch_pkg::AXIS_PARAM_WRITE_CMD); // RULE_13
            ax_wr_nv   = (instr == psch_pkg::AXIS_PARAM_STORE_CMD); // RULE_01
            ax_restore = (instr == psch_pkg::AXIS_PARAM_RESTORE_CMD); // RULE_02
            if (instr == psch_pkg::AXIS_PARAM_READ_CMD) begin
              rvalue   = axis_work[idx];
              acc_load = standalone_i; // RULE_14
            end
          end
        end
        psch_pkg::GLOBAL_PARAM_WRITE_CMD,
        psch_pkg::GLOBAL_PARAM_READ_CMD,
        psch_pkg::GLOBAL_PARAM_STORE_CMD,
        psch_pkg::GLOBAL_PARAM_RESTORE_CMD: begin
          if (!type_ok) begin
            status = psch_pkg::STAT_BAD_TYPE;
          end else if (!gbank_ok) begin
            status = psch_pkg::STAT_BAD_BANK; // RULE_05
          end else begin
            ok = 1'b1;
            gl_wr_work = (instr == psch_pkg::GLOBAL_PARAM_WRITE_CMD); // RULE_04
            gl_wr_nv   = (instr == psch_pkg::GLOBAL_PARAM_STORE_CMD) ||
                         (gl_wr_work && (gsel == psch_pkg::GB_SETTINGS)); // RULE_09 RULE_06
            gl_restore = (instr == psch_pkg::GLOBAL_PARAM_RESTORE_CMD); // RULE_10
            if (instr == psch_pkg::GLOBAL_PARAM_READ_CMD) begin
              rvalue   = glob_work[gsel][idx]; // RULE_08 RULE_12
              acc_load = standalone_i; // RULE_07 RULE_14
            end
          end
        end
        default: status = psch_pkg::STAT_BAD_CMD;
      endcase
      if (ok) begin
        status = psch_pkg::STAT_OK; // RULE_11
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= psch_pkg::ST_INIT;
    end else begin
      unique case (state_ff)
        psch_pkg::ST_INIT: begin
          if (init_idx_ff == IDX_LAST) begin
            state_ff <= psch_pkg::ST_RECV; // RULE_03
          end
        end
        psch_pkg::ST_RECV: begin
          if (rx_take && (cnt_ff == psch_pkg::CNT_LAST)) begin
            state_ff <= psch_pkg::ST_EXEC;
          end
        end
        psch_pkg::ST_EXEC: state_ff <= psch_pkg::ST_RECV;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_idx_ff <= IDX_ZERO;
      autorest_ff <= 1'b0;
    end else if (state_ff == psch_pkg::ST_INIT) begin
      init_idx_ff <= init_idx_ff + 1'b1;
      autorest_ff <= uvar_rest_en;
    end
  end

  // ---------------------------------------------------------------
  // Frame assembly
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff     <= psch_pkg::CNT_ZERO;
      csum_ff    <= 8'h00;
      csum_ok_ff <= 1'b0;
      addr_ok_ff <= 1'b0;
    end else if (rx_take) begin
      if (cnt_ff == psch_pkg::CNT_LAST) begin
        cnt_ff     <= psch_pkg::CNT_ZERO;
        csum_ff    <= 8'h00;
        csum_ok_ff <= (csum_ff == rx_data_i); // RULE_15
      end else begin
        cnt_ff  <= cnt_ff + 4'h1;
        csum_ff <= csum_ff + rx_data_i; // RULE_15
        if (cnt_ff == psch_pkg::CNT_ZERO) begin
          addr_ok_ff <= (rx_data_i == MODULE_ADDR);
        end
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rx_take && (cnt_ff != psch_pkg::CNT_LAST)) begin
      frame_ff[cnt_ff[2:0]] <= rx_data_i;
    end
  end

  // ---------------------------------------------------------------
  // Stores; restore and command writes never overlap in time
  // ---------------------------------------------------------------
  logic exec_go;
  assign exec_go = (state_ff == psch_pkg::ST_EXEC) && addr_ok_ff;

  always_ff @(posedge mclk_i) begin
    if (state_ff == psch_pkg::ST_INIT) begin
      axis_work[init_idx_ff] <= axis_nv[init_idx_ff]; // RULE_03
    end else if (exec_go && ax_wr_work) begin
      axis_work[idx] <= value; // RULE_13
    end else if (exec_go && ax_restore) begin
      axis_work[idx] <= axis_nv[idx]; // RULE_02
    end
  end

  always_ff @(posedge mclk_i) begin
    if (exec_go && ax_wr_nv) begin
      axis_nv[idx] <= axis_work[idx]; // RULE_01
    end
  end

  always_ff @(posedge mclk_i) begin
    if (state_ff == psch_pkg::ST_INIT) begin
      glob_work[psch_pkg::GB_SETTINGS][init_idx_ff] <=
        glob_nv[psch_pkg::GB_SETTINGS][init_idx_ff];
      if (uvar_rest_en) begin
        glob_work[psch_pkg::GB_USER][init_idx_ff] <=
          glob_nv[psch_pkg::GB_USER][init_idx_ff]; // RULE_10
      end
    end else if (exec_go && gl_wr_work) begin
      glob_work[gsel][idx] <= value; // RULE_04
    end else if (exec_go && gl_restore) begin
      glob_work[gsel][idx] <= glob_nv[gsel][idx]; // RULE_10
    end
  end

  always_ff @(posedge mclk_i) begin
    if (exec_go && gl_wr_nv) begin
      // Write path uses the frame value so bank 0 commits the new data
      glob_nv[gsel][idx] <= gl_wr_work ? value : glob_work[gsel][idx]; // RULE_06 RULE_09
    end
  end

  // ---------------------------------------------------------------
  // Reply and accumulator
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reply_valid_o  <= 1'b0;
      reply_instr_o  <= 8'h00;
      reply_status_o <= 8'h00;
      reply_value_o  <= psch_pkg::VAL_ZERO;
      nv_commit_o    <= 1'b0;
    end else begin
      // Frames for another address get no reply at all
      reply_valid_o <= exec_go;
      nv_commit_o   <= exec_go && (ax_wr_nv || gl_wr_nv);
      if (exec_go) begin
        reply_instr_o  <= instr;
        reply_status_o <= status; // RULE_11
        reply_value_o  <= rvalue; // RULE_08
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accumulator_o <= psch_pkg::VAL_ZERO;
    end else if (exec_go && acc_load) begin
      accumulator_o <= rvalue; // RULE_07
    end
  end

endmodule // psch_param_cmd

`default_nettype wire

// ===== tb/psch_host_model.sv
`timescale 1ns/1ns
`default_nettype none

module psch_host_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        go_i,
  input  wire logic        slow_i,
  input  wire logic        bad_i,
  input  wire logic [63:0] hdr_i,
  input  wire logic        rx_ready_i,
  output logic             rx_valid_o,
  output logic [7:0]       rx_data_o,
  output logic             busy_o
);
  logic [7:0] frm_ff [9];
  logic [3:0] idx_ff;
  logic [7:0] sum;

  // ---------------------------------------------------------------
  // Frame sender
  // ---------------------------------------------------------------
  always_comb begin
    sum = {7'h00, bad_i};
    for (int k = 0; k < 8; k++) begin
      sum = sum + hdr_i[63-8*k -: 8];
    end
  end

  // Released data shows the inverse of the last byte, never a stale copy
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o     <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_data_o  <= 8'h00;
      idx_ff     <= 4'h0;
    end else if (go_i && !busy_o) begin
      for (int k = 0; k < 8; k++) begin
        frm_ff[k] <= hdr_i[63-8*k -: 8];
      end
      frm_ff[8] <= sum;
      busy_o    <= 1'b1;
      idx_ff    <= 4'h0;
    end else if (busy_o && rx_valid_o && rx_ready_i) begin
      idx_ff <= idx_ff + 4'h1;
      busy_o <= (idx_ff != 4'h8);
      if (idx_ff != 4'h8 && !slow_i) begin
        rx_data_o <= frm_ff[idx_ff + 4'h1];
      end else begin
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~rx_data_o;
      end
    end else if (busy_o && !rx_valid_o) begin
      rx_valid_o <= 1'b1;
      rx_data_o  <= frm_ff[idx_ff];
    end
  end
endmodule // psch_host_model

`default_nettype wire

// ===== tb/psch_param_cmd_chk.sv
`timescale 1ns/1ns
`default_nettype none

module psch_param_cmd_chk #(
  parameter int PARAM_N = 256
) (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        rx_valid_i,
  input wire logic [7:0]  rx_data_i,
  input wire logic        rx_ready_o,
  input wire logic        standalone_i,
  input wire logic        uvar_autorestore_i,
  input wire logic        init_done_o,
  input wire logic        reply_valid_o,
  input wire logic [7:0]  reply_instr_o,
  input wire logic [7:0]  reply_status_o,
  input wire logic [31:0] reply_value_o,
  input wire logic [31:0] accumulator_o,
  input wire logic        nv_commit_o
);
  logic [3:0] cnt_ff;
  logic [7:0] sum_ff, adr_ff, ins_ff, typ_ff, bnk_ff;
  logic       end_ff, csok_ff;
  int         rcnt_ff;
  wire take = rx_valid_i && rx_ready_o;
  wire adr_ok = adr_ff == psch_pkg::DEF_ADDR;
  wire hdr_ok = end_ff && adr_ok && csok_ff;
  wire gcmd = ins_ff inside {[8'h09:8'h0c]};
  wire bnk_ok = gcmd ? bnk_ff inside {8'h00, 8'h02, 8'h03} : bnk_ff == 8'h00;
  wire cmd_ok = hdr_ok && ins_ff inside {[8'h05:8'h0c]} && typ_ff < PARAM_N && bnk_ok;
  wire want_cm = ins_ff inside {8'h07, 8'h0b} || (ins_ff == 8'h09 && bnk_ff == 8'h00);

  // ---------------------------------------------------------------
  // Frame tracking
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 4'h0;
      sum_ff <= 8'h00;
      end_ff <= 1'b0;
    end else begin
      end_ff <= take && cnt_ff == 4'h8;
      if (take) begin
        cnt_ff <= (cnt_ff == 4'h8) ? 4'h0 : cnt_ff + 4'h1;
        sum_ff <= (cnt_ff == 4'h8) ? 8'h00 : sum_ff + rx_data_i;
        csok_ff <= sum_ff == rx_data_i;
        case (cnt_ff)
          4'h0: adr_ff <= rx_data_i;
          4'h1: ins_ff <= rx_data_i;
          4'h2: typ_ff <= rx_data_i;
          4'h3: bnk_ff <= rx_data_i;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) rcnt_ff <= 0;
    else if (!init_done_o) rcnt_ff <= rcnt_ff + 1;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  a_reply_latency: assert property (hdr_ok |=> reply_valid_o && reply_instr_o == ins_ff)
    else $error("reply not two edges after frame");
  a_foreign_quiet: assert property (end_ff && !adr_ok |=> !reply_valid_o)
    else $error("reply to foreign address");
  a_bad_csum: assert property (end_ff && adr_ok && !csok_ff |=> reply_status_o == 8'h01)
    else $error("bad checksum not reported");
  a_ok_status: assert property (cmd_ok |=> reply_status_o == psch_pkg::STAT_OK)
    else $error("valid command not answered ok");
  a_bank_refused: assert property (hdr_ok && gcmd && !bnk_ok && typ_ff < PARAM_N
    |=> reply_status_o == 8'h04)
    else $error("unused bank accepted");
  a_commit_match: assert property (reply_valid_o |->
    nv_commit_o == (want_cm && reply_status_o == psch_pkg::STAT_OK))
    else $error("commit pulse wrong");
  a_store_zero: assert property (reply_valid_o && ins_ff inside {[8'h07:8'h09], 8'h0b, 8'h0c}
    |-> reply_value_o == 32'h0000_0000)
    else $error("nonzero value on non-read");
  a_direct_acc: assert property (!standalone_i [*2] |=> $stable(accumulator_o))
    else $error("accumulator moved in direct mode");
  a_acc_load: assert property (reply_valid_o && standalone_i && ins_ff == 8'h0a &&
    reply_status_o == psch_pkg::STAT_OK |-> accumulator_o == reply_value_o)
    else $error("accumulator not loaded");
  a_init_gate: assert property (!init_done_o |-> !rx_ready_o)
    else $error("ready during restore");
  a_restore_len: assert property ($rose(init_done_o) |-> rcnt_ff == PARAM_N)
    else $error("restore length wrong");

  c_commit: cover property (reply_valid_o && nv_commit_o);
  c_bad_csum: cover property (reply_valid_o && reply_status_o == 8'h01);
  c_acc_load: cover property (reply_valid_o && standalone_i && ins_ff == 8'h0a);
endmodule // psch_param_cmd_chk

bind psch_param_cmd psch_param_cmd_chk #(.PARAM_N(PARAM_N)) u_chk (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
  .rx_ready_o(rx_ready_o), .standalone_i(standalone_i),
  .uvar_autorestore_i(uvar_autorestore_i), .init_done_o(init_done_o),
  .reply_valid_o(reply_valid_o), .reply_instr_o(reply_instr_o),
  .reply_status_o(reply_status_o), .reply_value_o(reply_value_o),
  .accumulator_o(accumulator_o), .nv_commit_o(nv_commit_o));

`default_nettype wire

// ===== tb/parameter_store_command_handler_test.sv
`timescale 1ns/1ns
`default_nettype none

module parameter_store_command_handler_test;
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        go = 1'b0, slow = 1'b0, bad = 1'b0, sa = 1'b0, strap = 1'b1;
  logic [63:0] hdr = 64'h0;
  logic        rx_valid, rx_ready, init_done, rv, cm, busy;
  logic [7:0]  rx_data, r_ins, r_st;
  logic [31:0] r_val, acc;
  logic        got, g_cm;
  logic [7:0]  g_st, g_ins;
  logic [31:0] g_val;
  int          fail_count = 0, total_checks = 0, cyc = 0;
  localparam logic [7:0] OK = psch_pkg::STAT_OK;

  psch_param_cmd #(.PARAM_N(16)) dut (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid), .rx_data_i(rx_data),
    .rx_ready_o(rx_ready), .standalone_i(sa), .uvar_autorestore_i(strap),
    .init_done_o(init_done), .reply_valid_o(rv), .reply_instr_o(r_ins),
    .reply_status_o(r_st), .reply_value_o(r_val), .accumulator_o(acc), .nv_commit_o(cm));
  psch_host_model host (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .go_i(go), .slow_i(slow), .bad_i(bad),
    .hdr_i(hdr), .rx_ready_i(rx_ready), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
    .busy_o(busy));

  initial begin
    forever #10 mclk_i = ~mclk_i;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic do_reset();
    @(posedge mclk_i) rst_n_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(negedge mclk_i);
    chk("ready_in_restore", 1'b0, rx_ready);
    while (init_done !== 1'b1) @(negedge mclk_i);
  endtask

  // Next frame only after the reply or its absence is settled
  task automatic send(input logic [7:0] a, i, t, b, input logic [31:0] v);
    @(posedge mclk_i) hdr <= {a, i, t, b, v};
    go <= 1'b1;
    @(posedge mclk_i) go <= 1'b0;
    @(negedge mclk_i);
    while (busy === 1'b1) @(negedge mclk_i);
    got = 1'b0;
    repeat (6) begin
      @(negedge mclk_i);
      if (rv === 1'b1) begin
        got = 1'b1;
        g_st = r_st;
        g_val = r_val;
        g_cm = cm;
        g_ins = r_ins;
      end
    end
  endtask

  task automatic op(input logic [7:0] i, t, b, input logic [31:0] v,
                    input logic [7:0] est, input logic ecm);
    send(8'h01, i, t, b, v);
    chk("reply_seen", 1'b1, got);
    chk("instr", i, g_ins);
    chk("status", est, g_st);
    chk("commit", ecm, g_cm);
  endtask

  task automatic rd(input logic [7:0] i, t, b, input logic [31:0] e);
    op(i, t, b, 32'h0, OK, 1'b0);
    chk("value", e, g_val);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_axis();
    rd(8'h06, 8'h03, 8'h00, 32'h0);
    op(8'h05, 8'h03, 8'h00, 32'h1122_3344, OK, 1'b0);
    op(8'h07, 8'h03, 8'h00, 32'h0, OK, 1'b1);
    op(8'h05, 8'h03, 8'h00, 32'h5566_7788, OK, 1'b0);
    rd(8'h06, 8'h03, 8'h00, 32'h5566_7788);
    op(8'h08, 8'h03, 8'h00, 32'h0, OK, 1'b0);
    rd(8'h06, 8'h03, 8'h00, 32'h1122_3344);
    op(8'h05, 8'h03, 8'h00, 32'h0bad_0001, OK, 1'b0);
    op(8'h05, 8'h04, 8'h00, 32'h0bad_0002, OK, 1'b0);
    do_reset();
    rd(8'h06, 8'h03, 8'h00, 32'h1122_3344);
    rd(8'h06, 8'h04, 8'h00, 32'h0);
    $display("test axis done");
  endtask

  task automatic t_global();
    logic [7:0] bk;
    for (int k = 0; k < 3; k++) begin
      bk = (k == 0) ? 8'h00 : 8'(k + 1);
      op(8'h09, 8'h05, bk, 32'h8844_2200 | 32'(bk), OK, bk == 8'h00);
      rd(8'h0a, 8'h05, bk, 32'h8844_2200 | 32'(bk));
    end
    op(8'h09, 8'h05, 8'h01, 32'h1, 8'h04, 1'b0);
    $display("test global done");
  endtask

  task automatic t_user();
    op(8'h09, 8'h07, 8'h02, 32'hcafe_0001, OK, 1'b0);
    op(8'h0b, 8'h07, 8'h02, 32'h0, OK, 1'b1);
    op(8'h09, 8'h07, 8'h02, 32'hcafe_0002, OK, 1'b0);
    op(8'h0c, 8'h07, 8'h02, 32'h0, OK, 1'b0);
    rd(8'h0a, 8'h07, 8'h02, 32'hcafe_0001);
    op(8'h09, 8'h07, 8'h02, 32'hcafe_0003, OK, 1'b0);
    op(8'h09, 8'h06, 8'h00, 32'h0000_0042, OK, 1'b1);
    do_reset();
    rd(8'h0a, 8'h07, 8'h02, 32'hcafe_0001);
    rd(8'h0a, 8'h06, 8'h00, 32'h0000_0042);
    // Strap low: user variables keep their working value over reset
    op(8'h09, 8'h07, 8'h02, 32'hcafe_0003, OK, 1'b0);
    @(posedge mclk_i) strap <= 1'b0;
    do_reset();
    rd(8'h0a, 8'h07, 8'h02, 32'hcafe_0003);
    @(posedge mclk_i) strap <= 1'b1;
    op(8'h0c, 8'h07, 8'h02, 32'h0, OK, 1'b0);
    $display("test user done");
  endtask

  task automatic t_errors();
    @(posedge mclk_i) bad <= 1'b1;
    op(8'h09, 8'h07, 8'h02, 32'h1, 8'h01, 1'b0);
    @(posedge mclk_i) bad <= 1'b0;
    send(8'h02, 8'h09, 8'h07, 8'h02, 32'h2);
    chk("foreign_reply", 1'b0, got);
    op(8'h09, 8'h10, 8'h02, 32'h3, 8'h03, 1'b0);
    @(posedge mclk_i) slow <= 1'b1;
    rd(8'h0a, 8'h07, 8'h02, 32'hcafe_0001);
    @(posedge mclk_i) slow <= 1'b0;
    $display("test errors done");
  endtask

  task automatic t_accum();
    @(posedge mclk_i) sa <= 1'b1;
    rd(8'h0a, 8'h07, 8'h02, 32'hcafe_0001);
    chk("acc_load", 32'hcafe_0001, acc);
    @(posedge mclk_i) sa <= 1'b0;
    rd(8'h0a, 8'h06, 8'h00, 32'h0000_0042);
    chk("acc_direct", 32'hcafe_0001, acc);
    $display("test accum done");
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    do_reset();
    t_axis();
    t_global();
    t_user();
    t_errors();
    t_accum();
    report_and_stop();
  end
endmodule // parameter_store_command_handler_test

`default_nettype wire
